// file: ssfm_host_model.sv
/*
 * Host side of the register port: sub-address load, then a run of
 * one-cycle read or write strobes, all changed on the falling edge.
 * Assumes the same clock as the buffer block.
 */
`timescale 1ns/1ps
`default_nettype none

module ssfm_host_model (
	// clock
	input  wire logic  clk_sys_i,
	// register port strobes
	output logic       sub_load_o,
	output logic [7:0] sub_addr_o,
	output logic       reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic       reg_rd_o
);
	// ****************************************************************
	// idle state
	// ****************************************************************
	initial begin
		sub_load_o  = 1'b0;
		sub_addr_o  = 8'h00;
		reg_wr_o    = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o    = 1'b0;
	end

	// sub-address byte, top bit steps the pointer
	// released lines show the inverse, so stale values never look valid
	task automatic access(input logic [7:0] sub, input logic wr, input logic [7:0] d,
			input int n);
		@(negedge clk_sys_i);
		sub_load_o = 1'b1;
		sub_addr_o = sub;
		@(negedge clk_sys_i);
		sub_load_o = 1'b0;
		sub_addr_o = ~sub;
		repeat (n) begin
			reg_wr_o    = wr;
			reg_rd_o    = !wr;
			reg_wdata_o = d;
			@(negedge clk_sys_i);
		end
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_wdata_o = ~d;
	endtask
endmodule

`default_nettype wire

// file: ssfm_ingress_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock; width and depth are parameters, depth a
 * power of two.
 */
`timescale 1ns/1ps
`default_nettype none

module ssfm_ingress_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	// ****************************************************************
	// storage and pointers
	// ****************************************************************
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      fill_q;
	wire  logic       push;
	wire  logic       pop;

	// honest full/empty come straight from the fill count
	assign in_ready_o  = (fill_q != (AW+1)'(DEPTH));
	assign out_valid_o = (fill_q != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	// data array, no reset needed for payload
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q   <= '0;
			rd_q   <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			if (push && !pop) begin
				fill_q <= fill_q + (AW+1)'(1);
			end else if (pop && !push) begin
				fill_q <= fill_q - (AW+1)'(1);
			end
		end
	end

endmodule

`default_nettype wire

// file: ssfm_pkg.sv
/*
 * Shared constants of the sensor sample buffer: register addresses,
 * field positions, mode codes, reset values and buffer sizes.
 * Assumes a byte-wide register port with seven-bit register addresses.
 */
package ssfm_pkg;

	// ****************************************************************
	// buffer geometry
	// ****************************************************************
	localparam int          SAMPLE_W       = 40;
	localparam int          STORE_DEPTH    = 32;
	localparam int          PTR_W          = 5;
	localparam int          CNT_W          = 6;
	localparam int          INGRESS_DEPTH  = 16;
	localparam logic [5:0]  CNT_FULL       = 6'h20;
	localparam logic [5:0]  CNT_ONE        = 6'h01;
	localparam logic [5:0]  CNT_REOPEN     = 6'h02;
	localparam logic [4:0]  PTR_ONE        = 5'h01;
	localparam logic [4:0]  PTR_ZERO       = 5'h00;

	// ****************************************************************
	// register addresses
	// ****************************************************************
	localparam logic [6:0]  ADDR_INT_CFG   = 7'h0B;
	localparam logic [6:0]  ADDR_CTRL_TWO  = 7'h11;
	localparam logic [6:0]  ADDR_CTRL_THR  = 7'h12;
	localparam logic [6:0]  ADDR_BUF_CTRL  = 7'h14;
	localparam logic [6:0]  ADDR_BUF_STAT  = 7'h26;
	localparam logic [6:0]  ADDR_PRESS_XL  = 7'h28;
	localparam logic [6:0]  ADDR_PRESS_L   = 7'h29;
	localparam logic [6:0]  ADDR_PRESS_H   = 7'h2A;
	localparam logic [6:0]  ADDR_TEMP_L    = 7'h2B;
	localparam logic [6:0]  ADDR_TEMP_H    = 7'h2C;
	localparam logic [6:0]  ADDR_STEP      = 7'h01;
	localparam int          SUB_AUTOINC    = 7;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int          CT2_BUF_EN     = 6;
	localparam int          CT2_STOP_WM    = 5;
	localparam int          CT3_WM_IRQ     = 4;
	localparam int          CT3_OVR_IRQ    = 3;
	localparam int          BST_WM_FLAG    = 7;
	localparam int          BST_OVR_FLAG   = 6;
	localparam logic [7:0]  REG_RESET      = 8'h00;

	// ****************************************************************
	// mode codes and effective behaviours
	// ****************************************************************
	localparam logic [2:0]  MODE_BYPASS    = 3'h0;
	localparam logic [2:0]  MODE_FIFO      = 3'h1;
	localparam logic [2:0]  MODE_STREAM    = 3'h2;
	localparam logic [2:0]  MODE_STR2FIFO  = 3'h3;
	localparam logic [2:0]  MODE_BYP2STR   = 3'h4;
	localparam logic [2:0]  MODE_SPARE     = 3'h5;
	localparam logic [2:0]  MODE_DYNSTREAM = 3'h6;
	localparam logic [2:0]  MODE_BYP2FIFO  = 3'h7;

	typedef enum logic [1:0] {
		EFF_BYPASS = 2'h0,
		EFF_FIFO   = 2'h1,
		EFF_STREAM = 2'h3,
		EFF_DYN    = 2'h2
	} ssfm_eff_e;

endpackage

// file: ssfm_top.sv
/*
 * Sensor sample buffer: 32 x 40-bit store with seven modes, status,
 * watermark/overrun pin and the five output registers.
 * Assumes a protocol engine on the same clock that hands over the
 * sub-address byte, write bytes and read strobes, and a sensing chain
 * that pushes one sample per conversion.
 */
`timescale 1ns/1ps
`default_nettype none

module ssfm_top (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// samples from the conversion chain
	input  wire logic        sample_valid_i,
	output logic             sample_ready_o,
	input  wire logic [39:0] sample_data_i,
	// interrupt generator state
	input  wire logic        interrupt_active_i,
	// register port from the protocol engine
	input  wire logic        sub_load_i,
	input  wire logic [7:0]  sub_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	output logic             reg_rvalid_o,
	// pin
	output logic             data_ready_irq_pin_o
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [7:0]              int_cfg_q;
	logic [7:0]              ctrl_two_q;
	logic [7:0]              ctrl_three_q;
	logic [7:0]              buf_ctrl_q;
	logic [6:0]              addr_q;
	logic                    autoinc_q;
	logic [39:0]             hold_q;
	logic [7:0]              rdata_q;
	logic                    rvalid_q;
	logic                    pin_q;
	logic [39:0]             store_q [ssfm_pkg::STORE_DEPTH];
	logic [4:0]              wrp_q, wrp_d;
	logic [4:0]              rdp_q, rdp_d;
	logic [5:0]              cnt_q, cnt_d;
	logic                    ovr_q, ovr_d;
	logic                    ret_q, ret_d;
	logic                    st_we;
	logic [4:0]              st_wa;
	ssfm_pkg::ssfm_eff_e     eff;

	wire  logic              in_valid;
	wire  logic [39:0]       in_data;
	wire  logic              ingest;
	wire  logic              acc_rd;
	wire  logic              acc_wr;
	wire  logic              pop;
	wire  logic [2:0]        mode;
	wire  logic [4:0]        wm_level;
	wire  logic              buf_en;
	wire  logic              stop_wm;
	wire  logic [5:0]        depth;
	wire  logic              full;
	wire  logic              wm_flag;
	wire  logic [7:0]        status;
	wire  logic [39:0]       head_word;
	wire  logic [6:0]        addr_next;
	logic [7:0]              rd_mux;

	// ****************************************************************
	// ingress buffer
	// ****************************************************************
	// a host pop and a new sample never touch the store in one cycle;
	// the pop wins and the sample waits here
	ssfm_ingress_fifo #(
		.WIDTH (ssfm_pkg::SAMPLE_W),
		.DEPTH (ssfm_pkg::INGRESS_DEPTH)
	) u_ingress (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (sample_ready_o),
		.in_data_i   (sample_data_i),
		.out_valid_o (in_valid),
		.out_ready_i (!pop),
		.out_data_o  (in_data)
	);

	assign ingest = in_valid && !pop;

	// ****************************************************************
	// field decode
	// ****************************************************************
	assign mode     = buf_ctrl_q[7:5];
	assign wm_level = buf_ctrl_q[4:0];
	assign buf_en   = ctrl_two_q[ssfm_pkg::CT2_BUF_EN];
	assign stop_wm  = ctrl_two_q[ssfm_pkg::CT2_STOP_WM];
	assign depth    = stop_wm ? ({1'b0, wm_level} + ssfm_pkg::CNT_ONE)
	                          : ssfm_pkg::CNT_FULL;
	assign full     = (cnt_q >= depth);
	assign wm_flag  = (wm_level != 5'h00) && (cnt_q >= {1'b0, wm_level});
	assign status   = {wm_flag, ovr_q, cnt_q};
	assign head_word = store_q[rdp_q];

	// effective behaviour from mode code, enable and trigger state
	always_comb begin
		eff = ssfm_pkg::EFF_BYPASS;
		if (buf_en) begin
			unique case (mode)
				ssfm_pkg::MODE_BYPASS:    eff = ssfm_pkg::EFF_BYPASS;
				ssfm_pkg::MODE_FIFO:      eff = ssfm_pkg::EFF_FIFO;
				ssfm_pkg::MODE_STREAM:    eff = ssfm_pkg::EFF_STREAM;
				ssfm_pkg::MODE_DYNSTREAM: eff = ssfm_pkg::EFF_DYN;
				ssfm_pkg::MODE_STR2FIFO:  eff = interrupt_active_i ? ssfm_pkg::EFF_FIFO
				                                                   : ssfm_pkg::EFF_STREAM;
				ssfm_pkg::MODE_BYP2STR:   eff = interrupt_active_i ? ssfm_pkg::EFF_STREAM
				                                                   : ssfm_pkg::EFF_BYPASS;
				ssfm_pkg::MODE_BYP2FIFO:  eff = interrupt_active_i ? ssfm_pkg::EFF_FIFO
				                                                   : ssfm_pkg::EFF_BYPASS;
				ssfm_pkg::MODE_SPARE:     eff = ssfm_pkg::EFF_BYPASS; // undefined code parks
			endcase
		end
	end

	// ****************************************************************
	// register access decode
	// ****************************************************************
	// a sub-address load owns its cycle; any strobe beside it is dropped
	assign acc_rd = reg_rd_i && !sub_load_i;
	assign acc_wr = reg_wr_i && !sub_load_i && !reg_rd_i;
	assign pop    = acc_rd && (addr_q == ssfm_pkg::ADDR_PRESS_XL) &&
	                (eff != ssfm_pkg::EFF_BYPASS) && (cnt_q != 6'h00);
	assign addr_next = (addr_q == ssfm_pkg::ADDR_TEMP_H) ? ssfm_pkg::ADDR_PRESS_XL
	                                                     : addr_q + ssfm_pkg::ADDR_STEP;

	// read mux; unmapped addresses answer zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (addr_q)
			ssfm_pkg::ADDR_INT_CFG:  rd_mux = int_cfg_q;
			ssfm_pkg::ADDR_CTRL_TWO: rd_mux = ctrl_two_q;
			ssfm_pkg::ADDR_CTRL_THR: rd_mux = ctrl_three_q;
			ssfm_pkg::ADDR_BUF_CTRL: rd_mux = buf_ctrl_q;
			ssfm_pkg::ADDR_BUF_STAT: rd_mux = status;
			ssfm_pkg::ADDR_PRESS_XL: rd_mux = pop ? head_word[7:0] : hold_q[7:0];
			ssfm_pkg::ADDR_PRESS_L:  rd_mux = hold_q[15:8];
			ssfm_pkg::ADDR_PRESS_H:  rd_mux = hold_q[23:16];
			ssfm_pkg::ADDR_TEMP_L:   rd_mux = hold_q[31:24];
			ssfm_pkg::ADDR_TEMP_H:   rd_mux = hold_q[39:32];
			default:                 rd_mux = 8'h00;
		endcase
	end

	// ****************************************************************
	// store pointer and flag next state
	// ****************************************************************
	always_comb begin
		wrp_d = wrp_q;
		rdp_d = rdp_q;
		cnt_d = cnt_q;
		ovr_d = ovr_q;
		ret_d = ret_q;
		st_we = 1'b0;
		st_wa = wrp_q;
		// reading status clears overrun, but a new overwrite wins below
		if (acc_rd && (addr_q == ssfm_pkg::ADDR_BUF_STAT)) begin
			ovr_d = 1'b0;
		end
		if (eff == ssfm_pkg::EFF_BYPASS) begin
			// held flushed; only slot zero is ever written
			wrp_d = ssfm_pkg::PTR_ZERO;
			rdp_d = ssfm_pkg::PTR_ZERO;
			cnt_d = 6'h00;
			ovr_d = 1'b0;
			ret_d = 1'b0;
			st_we = ingest;
			st_wa = ssfm_pkg::PTR_ZERO;
		end else if (pop) begin
			rdp_d = rdp_q + ssfm_pkg::PTR_ONE;
			cnt_d = cnt_q - ssfm_pkg::CNT_ONE;
			ret_d = 1'b1;
		end else if (ingest) begin
			if (eff == ssfm_pkg::EFF_FIFO) begin
				if (!full) begin
					st_we = 1'b1;
					wrp_d = wrp_q + ssfm_pkg::PTR_ONE;
					cnt_d = cnt_q + ssfm_pkg::CNT_ONE;
				end
			end else begin
				st_we = 1'b1;
				wrp_d = wrp_q + ssfm_pkg::PTR_ONE;
				if (full) begin
					rdp_d = rdp_q + ssfm_pkg::PTR_ONE;
					ovr_d = 1'b1;
				end else if ((cnt_q == 6'h00) && ret_q && (eff == ssfm_pkg::EFF_STREAM)) begin
					// last read sample becomes unread again
					rdp_d = rdp_q - ssfm_pkg::PTR_ONE;
					cnt_d = ssfm_pkg::CNT_REOPEN;
				end else begin
					cnt_d = cnt_q + ssfm_pkg::CNT_ONE;
				end
			end
		end
	end

	// sample array, payload only
	always_ff @(posedge clk_sys_i) begin
		if (st_we) begin
			store_q[st_wa] <= in_data;
		end
	end

	// store control state
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wrp_q <= ssfm_pkg::PTR_ZERO;
			rdp_q <= ssfm_pkg::PTR_ZERO;
			cnt_q <= 6'h00;
			ovr_q <= 1'b0;
			ret_q <= 1'b0;
		end else begin
			wrp_q <= wrp_d;
			rdp_q <= rdp_d;
			cnt_q <= cnt_d;
			ovr_q <= ovr_d;
			ret_q <= ret_d;
		end
	end

	// ****************************************************************
	// output holding registers
	// ****************************************************************
	// bypass shows the newest sample, buffered modes the popped one
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= '0;
		end else if (pop) begin
			hold_q <= head_word;
		end else if ((eff == ssfm_pkg::EFF_BYPASS) && ingest) begin
			hold_q <= in_data;
		end
	end

	// ****************************************************************
	// control registers and address pointer
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_cfg_q    <= ssfm_pkg::REG_RESET;
			ctrl_two_q   <= ssfm_pkg::REG_RESET;
			ctrl_three_q <= ssfm_pkg::REG_RESET;
			buf_ctrl_q   <= ssfm_pkg::REG_RESET;
		end else if (acc_wr) begin
			unique case (addr_q)
				ssfm_pkg::ADDR_INT_CFG:  int_cfg_q    <= reg_wdata_i;
				ssfm_pkg::ADDR_CTRL_TWO: ctrl_two_q   <= reg_wdata_i;
				ssfm_pkg::ADDR_CTRL_THR: ctrl_three_q <= reg_wdata_i;
				ssfm_pkg::ADDR_BUF_CTRL: buf_ctrl_q   <= reg_wdata_i;
				default:                 ;
			endcase
		end
	end

	// sub-address pointer with auto increment
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q    <= 7'h00;
			autoinc_q <= 1'b0;
		end else if (sub_load_i) begin
			addr_q    <= sub_addr_i[6:0];
			autoinc_q <= sub_addr_i[ssfm_pkg::SUB_AUTOINC];
		end else if ((acc_rd || acc_wr) && autoinc_q) begin
			addr_q <= addr_next;
		end
	end

	// read data and pin, all from flip-flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
			pin_q    <= 1'b0;
		end else begin
			rvalid_q <= acc_rd;
			if (acc_rd) begin
				rdata_q <= rd_mux;
			end
			pin_q <= (ctrl_three_q[ssfm_pkg::CT3_WM_IRQ] && wm_flag) ||
			         (ctrl_three_q[ssfm_pkg::CT3_OVR_IRQ] && ovr_q);
		end
	end

	assign reg_rdata_o          = rdata_q;
	assign reg_rvalid_o         = rvalid_q;
	assign data_ready_irq_pin_o = pin_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_wm_zero_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wm_level == 5'h00) |-> !wm_flag) else $error("watermark flag with zero level");
	a_wm_level_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wm_flag == ((wm_level != 5'h00) && (cnt_q >= {1'b0, wm_level})))
		else $error("watermark flag disagrees with count");
	a_count_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cnt_q <= ssfm_pkg::CNT_FULL) else $error("unread count above 32");
	a_fifo_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(eff == ssfm_pkg::EFF_FIFO && full && ingest) |=> (cnt_q == $past(cnt_q)))
		else $error("fifo mode accepted sample when full");
	a_bypass_empty: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(eff == ssfm_pkg::EFF_BYPASS) |=> (cnt_q == 6'h00) && !ovr_q)
		else $error("bypass left samples or overrun");
	a_stream_reopen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(eff == ssfm_pkg::EFF_STREAM && cnt_q == 6'h00 && ret_q && ingest && !full)
		|=> (cnt_q == 6'h02)) else $error("stream count did not step to two");
	a_dyn_newonly: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(eff == ssfm_pkg::EFF_DYN && cnt_q == 6'h00 && ingest && !full)
		|=> (cnt_q == 6'h01)) else $error("dynamic stream count not one");
	a_overrun_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(eff inside {ssfm_pkg::EFF_STREAM, ssfm_pkg::EFF_DYN} && full && ingest)
		|=> ovr_q ##1 (pin_q || !ctrl_three_q[ssfm_pkg::CT3_OVR_IRQ]))
		else $error("overwrite did not raise overrun");
	a_pin_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pin_q == $past((ctrl_three_q[ssfm_pkg::CT3_WM_IRQ] && wm_flag) ||
		               (ctrl_three_q[ssfm_pkg::CT3_OVR_IRQ] && ovr_q)))
		else $error("data ready pin wrong");
	a_addr_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(acc_rd && autoinc_q && addr_q == ssfm_pkg::ADDR_TEMP_H)
		|=> (addr_q == ssfm_pkg::ADDR_PRESS_XL)) else $error("burst address did not wrap");
	a_pop_loads: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pop |=> (hold_q == $past(head_word)) && reg_rvalid_o &&
		        (reg_rdata_o == $past(head_word[7:0])))
		else $error("buffer read did not load oldest sample");

endmodule

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench of the sample buffer: fills, drains and flushes
 * it in several modes and compares read bytes and status.
 * Assumes the host model of the same folder.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        sv_i      = 1'b0;
	logic        ia_i      = 1'b0;
	logic [39:0] sd_i      = 40'h0;
	logic        sr_o, sl, wr, rd, rv, pin;
	logic [7:0]  sa, wd, rdat;
	logic [39:0] mdl[$];
	logic [7:0]  exp_q[$];
	logic [39:0] last_s;
	int          errors = 0, samples_checked = 0, md = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	ssfm_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_valid_i(sv_i),
		.sample_ready_o(sr_o), .sample_data_i(sd_i), .interrupt_active_i(ia_i),
		.sub_load_i(sl), .sub_addr_i(sa), .reg_wr_i(wr), .reg_wdata_i(wd),
		.reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
		.data_ready_irq_pin_o(pin));
	ssfm_host_model u_host (.clk_sys_i(clk_sys_i), .sub_load_o(sl), .sub_addr_o(sa),
		.reg_wr_o(wr), .reg_wdata_o(wd), .reg_rd_o(rd));

	// ****************************************************************
	// checking and closing
	// ****************************************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// read data is settled by the falling edge of its valid cycle
	always @(negedge clk_sys_i) begin
		if (rv === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unexpected read", 8'h00, 8'hFF);
			else
				chk("reg_rdata_o", exp_q.pop_front(), rdat);
		end
	end

	// ****************************************************************
	// drivers
	// ****************************************************************
	task automatic wrr(input logic [6:0] a, input logic [7:0] d);
		u_host.access({1'b0, a}, 1'b1, d, 1);
	endtask

	task automatic rdr(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.access({1'b0, a}, 1'b0, 8'h00, 1);
		repeat (2) @(negedge clk_sys_i);
	endtask

	// burst of whole samples; the pointer wraps 2Ch to 28h inside it
	task automatic rds(input int n);
		logic [39:0] s;
		for (int i = 0; i < n; i++) begin
			s = mdl.pop_front();
			for (int b = 0; b < 5; b++)
				exp_q.push_back(s[8*b +: 8]);
		end
		u_host.access(8'hA8, 1'b0, 8'h00, 5 * n);
		repeat (2) @(negedge clk_sys_i);
	endtask

	// model: md 1 fifo keeps the first 32, md 2 stream drops oldest
	task automatic push(input int k);
		repeat (k) begin
			@(negedge clk_sys_i);
			sv_i = 1'b1;
			sd_i = {8'($urandom_range(255, 0)), $urandom()};
			do @(posedge clk_sys_i); while (sr_o !== 1'b1);
			last_s = sd_i;
			if (md == 1 && mdl.size() < 32)
				mdl.push_back(sd_i);
			if (md == 2) begin
				if (mdl.size() == 32)
					void'(mdl.pop_front());
				mdl.push_back(sd_i);
			end
			@(negedge clk_sys_i);
			sv_i = 1'b0;
			sd_i = ~sd_i;
			repeat (3) @(negedge clk_sys_i);
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		logic [7:0] v[4];
		logic [6:0] a[4];
		void'($urandom(32'h592B1C4C));
		repeat (10) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		// reset values, then write and read back every control register
		a = '{7'h0B, 7'h11, 7'h12, 7'h14};
		v = '{8'h80 | 8'($urandom_range(255, 0)), 8'h40, 8'h08, 8'h24};
		for (int i = 0; i < 4; i++) begin
			rdr(a[i], 8'h00);
			wrr(a[i], v[i]);
			rdr(a[i], v[i]);
		end
		wrr(7'h26, 8'hFF);
		rdr(7'h26, 8'h00);
		rdr(7'h7F, 8'h00);
		// fifo mode, watermark 4: overfill, keep 32, no overrun
		md = 1;
		push(34);
		chk("pin", 8'h00, {7'h0, pin});
		rdr(7'h26, 8'hA0);
		rds(2);
		rdr(7'h26, 8'h9E);
		// stream, watermark 0: overflow drops oldest, raises overrun
		md = 2;
		wrr(7'h14, 8'h40);
		push(3);
		chk("pin", 8'h01, {7'h0, pin});
		rdr(7'h26, 8'h60);
		repeat (2) @(negedge clk_sys_i);
		chk("pin", 8'h00, {7'h0, pin});
		rds(1);
		// bypass flushes; output bytes follow the newest sample
		md = 0;
		wrr(7'h14, 8'h00);
		rdr(7'h26, 8'h00);
		push(1);
		mdl = '{last_s};
		rds(1);
		// stop on watermark 3 limits depth to four
		md = 1;
		wrr(7'h11, 8'h60);
		wrr(7'h14, 8'h23);
		push(6);
		rdr(7'h26, 8'h84);
		// the host reads away the first sample after entering fifo mode
		rds(1);
		wrr(7'h11, 8'h40);
		// trigger-driven modes follow the interrupt-active level
		foreach (v[i]) v[i] = 8'h00;
		v[0] = 8'h03;
		v[1] = 8'h04;
		v[2] = 8'h07;
		for (int i = 0; i < 3; i++) begin
			wrr(7'h14, 8'h00);
			wrr(7'h14, {v[i][2:0], 5'h00});
			ia_i = 1'b0;
			push(2);
			rdr(7'h26, (i == 0) ? 8'h02 : 8'h00);
			ia_i = 1'b1;
			push(2);
			rdr(7'h26, (i == 0) ? 8'h04 : 8'h02);
		end
		// stream keeps the last read sample; dynamic stream counts new ones only
		md = 2;
		mdl.delete();
		wrr(7'h14, 8'h00);
		wrr(7'h14, 8'h40);
		push(2);
		rds(2);
		mdl.push_back(last_s);
		push(1);
		rdr(7'h26, 8'h02);
		rds(2);
		wrr(7'h14, 8'hC0);
		push(1);
		rdr(7'h26, 8'h01);
		rds(1);
		// watermark level 2 drives the pin while enabled, drops once drained
		wrr(7'h12, 8'h10);
		wrr(7'h14, 8'hC2);
		push(2);
		chk("pin", 8'h01, {7'h0, pin});
		rdr(7'h26, 8'h82);
		rds(2);
		chk("pin", 8'h00, {7'h0, pin});
		// the spare mode code parks the buffer flushed like bypass
		push(1);
		wrr(7'h14, 8'hA0);
		rdr(7'h26, 8'h00);
		mdl.delete();
		// a reset in mid-run returns every register to zero
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		chk("sample_ready_o", 8'h01, {7'h0, sr_o});
		rdr(7'h12, 8'h00);
		rdr(7'h26, 8'h00);
		chk("pending reads", 8'h00, 8'(exp_q.size()));
		wrap_up();
	end

	// watchdog well beyond the several hundred cycles the tests need
	initial begin
		#500000;
		errors++;
		wrap_up();
	end
endmodule

`default_nettype wire
